// ---- rtl/vpb_bus_control.sv ----
// i2c alignment receiver with vblank-synchronised buffer and pulse gating
// assumes comparator results arrive as async logic levels; scl/sda sampled at 20 MHz
//
// The AXI4-Lite register port and the address map were left to the implementer.
module vpb_bus_control (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // i2c pins, open drain
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  // comparator levels
  input  wire logic                 clamp_vblank_input_lo,
  input  wire logic                 clamp_vblank_input_hi,
  input  wire logic                 flyback_pulse_input_lo,
  input  wire logic                 flyback_pulse_input_hi,
  input  wire logic                 fast_blank_input,
  input  wire logic [2:0]           overlay_colour_inputs,
  input  wire logic                 supply_dip,
  // results
  output vpb_pkg::vpb_align_t       align_o,
  output vpb_pkg::vpb_ctrl_t        ctrl_o,
  output vpb_pkg::vpb_video_t       video_o,
  output logic                      vblank_o
);
  import vpb_pkg::*;

  localparam int NSYNC = 11;

  function automatic logic [7:0] reg_mask(input logic [6:0] idx);
    if (idx == IDX_CTRL) reg_mask = MASK_CTRL;
    else if (idx == IDX_OSDC) reg_mask = MASK_OSDC;
    else if (idx == IDX_ACBL) reg_mask = MASK_ACBL;
    else if (idx == IDX_PED) reg_mask = MASK_PED;
    else reg_mask = MASK_FULL;
  endfunction

  function automatic logic [7:0] reg_init(input logic [6:0] idx);
    reg_init = (idx == IDX_CTRL) ? CTRL_INIT : ALIGN_INIT;
  endfunction

  // two-stage synchronisers, left unreset so they track the idle pins through reset and no
  // false scl or sda edge follows its release; only stage 2 is read
  logic [NSYNC-1:0] raw_w, s1_r, s2_r;
  logic             scl_d_r, sda_d_r, dip_d_r;
  assign raw_w = {supply_dip, overlay_colour_inputs, fast_blank_input, flyback_pulse_input_hi,
                  flyback_pulse_input_lo, clamp_vblank_input_hi, clamp_vblank_input_lo, sda_i, scl_i};
  always_ff @(posedge aclk) begin
    s1_r <= raw_w;
    s2_r <= s1_r;
  end

  logic       scl_s, sda_s, cli_lo, cli_hi, fly_lo, fly_hi, fbl_s, dip_s;
  logic [2:0] osd_s;
  assign scl_s  = s2_r[0];
  assign sda_s  = s2_r[1];
  assign cli_lo = s2_r[2];
  assign cli_hi = s2_r[3];
  assign fly_lo = s2_r[4];
  assign fly_hi = s2_r[5];
  assign fbl_s  = s2_r[6];
  assign osd_s  = s2_r[9:7];
  assign dip_s  = s2_r[10];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      dip_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      dip_d_r <= dip_s;
    end
  end

  logic scl_rise, scl_fall, i2c_start, i2c_stop, dip_rise;
  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;
  assign i2c_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign i2c_stop  = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign dip_rise  = dip_s && !dip_d_r;

  // vblank: level between the two thresholds; a clamp pulse above the upper one masks it
  logic       vb_src_w, vblank_r, vblank_d_r, vb_edge;
  logic [3:0] vb_cnt_r;
  assign vb_src_w = cli_lo && !cli_hi;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vblank_r <= 1'b0;
      vb_cnt_r <= '0;
    end else if (vb_src_w != vblank_r) begin
      if (vb_cnt_r == 4'((vb_src_w ? VB_RISE_CYC : VB_FALL_CYC) - 1)) begin
        vblank_r <= vb_src_w;
        vb_cnt_r <= '0;
      end else begin
        vb_cnt_r <= vb_cnt_r + 4'h1;
      end
    end else begin
      vb_cnt_r <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) vblank_d_r <= 1'b0;
    else vblank_d_r <= vblank_r;
  end
  assign vb_edge = vblank_r && !vblank_d_r;

  // register storage and control state
  logic [7:0]          regs_r [NUM_REGS];
  logic [7:0]          shadow_r [NUM_REGS];
  logic [NUM_REGS-1:0] dirty_r;
  logic [7:0]          hold_r;
  logic [6:0]          hold_idx_r;
  logic                byte_got_r, pend_r, flag_r;
  logic [6:0]          slave_addr_r;

  vpb_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [6:0] sub_idx_r;
  logic       buf_mode_r, sda_oe_r;

  logic byte_done, addr_ok, sub_ok, data_ok, data_take, sub_take, xfer_end;
  assign byte_done = scl_fall && (bit_cnt_r == BITS_BYTE);
  assign addr_ok   = (shift_r[7:1] == slave_addr_r) && !shift_r[0];
  assign sub_ok    = (shift_r[6:0] < 7'(NUM_REGS)) && !(shift_r[SUB_MODE] && pend_r);
  assign data_ok   = !flag_r && (sub_idx_r < 7'(NUM_REGS)) && !(buf_mode_r && byte_got_r);
  assign data_take = (state_r == VPB_DATA) && byte_done && data_ok;
  assign sub_take  = (state_r == VPB_SUB) && byte_done && sub_ok;
  assign xfer_end  = i2c_stop && (state_r != VPB_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn || dip_rise) begin
      state_r   <= VPB_IDLE;
      bit_cnt_r <= '0;
      shift_r   <= '0;
      sda_oe_r  <= 1'b0;
    end else if (i2c_start) begin
      state_r   <= VPB_ADDR;
      bit_cnt_r <= '0;
      sda_oe_r  <= 1'b0;
    end else if (i2c_stop) begin
      state_r  <= VPB_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        VPB_ADDR, VPB_SUB, VPB_DATA: begin
          if (scl_rise && bit_cnt_r != BITS_BYTE) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            bit_cnt_r <= '0;
            if (state_r == VPB_ADDR) begin
              state_r  <= addr_ok ? VPB_ADDR_ACK : VPB_IGNORE;
              sda_oe_r <= addr_ok;
            end else if (state_r == VPB_SUB) begin
              state_r  <= sub_ok ? VPB_SUB_ACK : VPB_IGNORE;
              sda_oe_r <= sub_ok;
            end else begin
              state_r  <= data_ok ? VPB_DATA_ACK : VPB_IGNORE;
              sda_oe_r <= data_ok;
            end
          end
        end
        VPB_ADDR_ACK, VPB_SUB_ACK, VPB_DATA_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= (state_r == VPB_ADDR_ACK) ? VPB_SUB : VPB_DATA;
          end
        end
        default: sda_oe_r <= 1'b0;
      endcase
    end
  end

  // subaddress pointer and mode latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_idx_r  <= '0;
      buf_mode_r <= 1'b0;
    end else if (sub_take) begin
      sub_idx_r  <= shift_r[6:0];
      buf_mode_r <= shift_r[SUB_MODE];
    end else if (data_take && !buf_mode_r) begin
      sub_idx_r <= sub_idx_r + 7'h01;
    end
  end

  // staging: direct bytes in a shadow set, buffered byte in the single hold
  always_ff @(posedge aclk) begin
    if (!aresetn || dip_rise || i2c_start) begin
      dirty_r    <= '0;
      byte_got_r <= 1'b0;
    end else if (xfer_end) begin
      dirty_r    <= '0;
      byte_got_r <= 1'b0;
    end else if (data_take) begin
      if (buf_mode_r) byte_got_r <= 1'b1;
      else dirty_r[sub_idx_r[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r     <= '0;
      hold_idx_r <= '0;
      for (int i = 0; i < NUM_REGS; i++) shadow_r[i] <= '0;
    end else if (data_take) begin
      if (buf_mode_r) begin
        hold_r     <= shift_r;
        hold_idx_r <= sub_idx_r;
      end else begin
        shadow_r[sub_idx_r[3:0]] <= shift_r;
      end
    end
  end

  // pending buffered byte; a new one cannot start while this is set
  always_ff @(posedge aclk) begin
    if (!aresetn || dip_rise) pend_r <= 1'b0;
    else if (xfer_end && byte_got_r) pend_r <= 1'b1;
    else if (vb_edge) pend_r <= 1'b0;
  end

  // dip flag; set wins over the clear by addressing the control register
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_r <= 1'b0;
    else if (dip_rise) flag_r <= 1'b1;
    else if (sub_take && shift_r[6:0] == IDX_CTRL) flag_r <= 1'b0;
  end

  // live alignment registers
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (!aresetn || dip_rise) begin
          regs_r[g] <= reg_init(7'(g));
        end else if (vb_edge && pend_r && hold_idx_r == 7'(g)) begin
          regs_r[g] <= hold_r & reg_mask(7'(g));
        end else if (xfer_end && dirty_r[g]) begin
          regs_r[g] <= shadow_r[g] & reg_mask(7'(g));
        end
      end
    end
  endgenerate

  assign align_o = {regs_r[11], regs_r[10], regs_r[9], regs_r[8], regs_r[7], regs_r[6],
                    regs_r[5], regs_r[4], regs_r[3], regs_r[2], regs_r[1], regs_r[0]};
  // control bits live in the low nibble of register 0
  assign ctrl_o = '{brightness_tracking_select: regs_r[0][BIT_TRACK],
                    feedback_polarity_select:   regs_r[0][BIT_FEEDBACK_POLARITY_SELECT],
                    video_disable:              regs_r[0][BIT_VDIS],
                    overlay_disable:            regs_r[0][BIT_ODIS]};

  // pulse gating, one flop stage behind the synchronisers
  logic overlay_on;
  assign overlay_on = fbl_s && !regs_r[0][BIT_ODIS];
  vpb_video_t video_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      video_r <= '0;
    end else begin
      video_r.signal_blank   <= vblank_r || fly_lo || overlay_on || regs_r[0][BIT_VDIS];
      video_r.bright_blank   <= vblank_r || fly_lo;
      video_r.pedestal_blank <= vblank_r || fly_lo;
      video_r.input_clamp    <= cli_hi;
      video_r.output_clamp   <= fly_hi;
      video_r.overlay_enable <= overlay_on;
      video_r.overlay_insert <= overlay_on ? osd_s : 3'h0;
    end
  end
  assign video_o  = video_r;
  assign vblank_o = vblank_d_r;
  assign sda_oe   = sda_oe_r;
  assign sda_o    = 1'b0;

  // axi4-lite slave
  logic       aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb_r      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      slave_addr_r  <= SLAVE_ADDR_INIT;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_r && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == A_SLAVE) begin
          s_axi_bresp <= RESP_OKAY;
          if (w_strb_r[0]) slave_addr_r <= w_data_r[6:0];
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == A_SLAVE) begin
          s_axi_rdata <= {25'h0, slave_addr_r};
        end else if (s_axi_araddr == A_STATUS) begin
          s_axi_rdata <= {29'h0, vblank_r, pend_r, flag_r};
        end else if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[7:2] < 6'(NUM_REGS)) begin
          s_axi_rdata <= {24'h0, regs_r[s_axi_araddr[5:2]]};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence vb_src_held_high;
    !vblank_r && vb_cnt_r == 4'h0 && vb_src_w ##0 vb_src_w [*6];
  endsequence
  sequence vb_src_held_low;
    vblank_r && vb_cnt_r == 4'h0 && !vb_src_w ##0 (!vb_src_w) [*2];
  endsequence

  chk_vb_rise_delay: assert property (vb_src_held_high |=> vblank_r)
    else $error("vblank did not rise after six cycles");
  chk_vb_fall_delay: assert property (vb_src_held_low |=> !vblank_r)
    else $error("vblank did not fall after two cycles");
  chk_vblank_blank_group: assert property (vblank_r |=>
    video_r.signal_blank && video_r.bright_blank && video_r.pedestal_blank)
    else $error("vblank without full blanking");
  chk_flyback_clamp: assert property (fly_hi && fly_lo |=> video_r.output_clamp && video_r.signal_blank)
    else $error("flyback high level did not clamp and blank");
  chk_overlay_disabled: assert property (regs_r[0][BIT_ODIS] |=>
    !video_r.overlay_enable && video_r.overlay_insert == 3'h0)
    else $error("overlay active while disabled");
  chk_buffered_nack: assert property ((state_r == VPB_SUB) && byte_done && shift_r[SUB_MODE] && pend_r
    |=> state_r == VPB_IGNORE && !sda_oe_r)
    else $error("second buffered transfer acknowledged");
  chk_buffered_apply: assert property (vb_edge && pend_r |=>
    !pend_r && regs_r[$past(hold_idx_r[3:0])] == ($past(hold_r) & reg_mask($past(hold_idx_r))))
    else $error("buffered byte not applied at vblank");
  chk_dip_restore: assert property (dip_rise |=> flag_r && regs_r[0] == CTRL_INIT && !pend_r)
    else $error("supply dip did not restore defaults");
  chk_flag_nack: assert property ((state_r == VPB_DATA) && byte_done && flag_r |=> !sda_oe_r)
    else $error("data acknowledged while reset flag set");
  chk_direct_increment: assert property (data_take && !buf_mode_r |=> sub_idx_r == $past(sub_idx_r) + 7'h01)
    else $error("direct subaddress did not advance");

endmodule

// ---- rtl/vpb_pkg.sv ----
// constants, types and layouts for the video preamp bus control block
// assumes a single 20 MHz clock; all pins arrive asynchronously
// Notes on behaviour
// - subaddress msb one buffered, zero direct
// - buffered: one transfer per vblank, others nacked
// - buffered byte kept in one 8-bit hold
// - buffered byte applied on next vblank start
// - power-on reset cancels pending buffered wait
// - buffered mode has no auto-increment, one byte
// - direct mode accepts unlimited transfers
// - direct writes take effect at stop
// - direct mode subaddress increments per byte
// - reset: polarity one, everything else zero
// - supply dip restores defaults, sets flag, nacks data
// - flag clears when control register addressed
// - clamp input: low level vblank, high clamp
// - vblank rises 270 ns, falls 115 ns late; the code rounds to 6 cycles (300 ns) and 2 cycles (100 ns)
// - vblank forces signal, brightness, pedestal blanking
// - clamping and vblank handled independently
// - flyback low blanks, high also clamps output
// - fast blank blanks video, enables overlay colours
// - overlay disable ignores fast blank and colours
// - polarity one internal feedback, zero external
// - register widths 8, 4, 3 and 2 bits
// - control register carries the four control bits
// - black-level reference resets to zero code
// - video disable forces signal blanking
// - tracking select one disables grey scale tracking
package vpb_pkg;

  localparam int          NUM_REGS   = 12;
  localparam logic [6:0]  IDX_CTRL   = 7'h00;
  localparam logic [6:0]  IDX_OSDC   = 7'h02;
  localparam logic [6:0]  IDX_ACBL   = 7'h0A;
  localparam logic [6:0]  IDX_PED    = 7'h0B;
  localparam logic [7:0]  MASK_FULL  = 8'hFF;
  localparam logic [7:0]  MASK_CTRL  = 8'h0F;
  localparam logic [7:0]  MASK_OSDC  = 8'h0F;
  localparam logic [7:0]  MASK_ACBL  = 8'h07;
  localparam logic [7:0]  MASK_PED   = 8'h03;
  localparam logic [7:0]  CTRL_INIT  = 8'h02;
  localparam logic [7:0]  ALIGN_INIT = 8'h00;
  localparam int          BIT_TRACK  = 0;
  localparam int          BIT_FEEDBACK_POLARITY_SELECT   = 1;
  localparam int          BIT_VDIS   = 2;
  localparam int          BIT_ODIS   = 3;
  localparam int          SUB_MODE   = 7;
  localparam logic [6:0]  SLAVE_ADDR_INIT = 7'h44;

  // axi byte addresses
  localparam logic [7:0]  A_SLAVE    = 8'h40;
  localparam logic [7:0]  A_STATUS   = 8'h44;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          ST_FLAG    = 0;
  localparam int          ST_PEND    = 1;
  localparam int          ST_VBLANK  = 2;

  localparam int          CLK_NS       = 50;
  localparam int          VB_RISE_NS   = 270;
  localparam int          VB_FALL_NS   = 115;
  localparam int          VB_RISE_CYC  = (VB_RISE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          VB_FALL_CYC  = (VB_FALL_NS / CLK_NS) < 1 ? 1 : VB_FALL_NS / CLK_NS;
  localparam logic [3:0]  BITS_BYTE    = 4'h8;

  typedef enum logic [2:0] {
    VPB_IDLE     = 3'h0,
    VPB_ADDR     = 3'h1,
    VPB_ADDR_ACK = 3'h3,
    VPB_SUB      = 3'h2,
    VPB_SUB_ACK  = 3'h6,
    VPB_DATA     = 3'h7,
    VPB_DATA_ACK = 3'h5,
    VPB_IGNORE   = 3'h4
  } vpb_state_t;

  typedef struct packed {
    logic [7:0] pedestal;
    logic [7:0] ac_black;
    logic [7:0] fb_ref_3;
    logic [7:0] fb_ref_2;
    logic [7:0] fb_ref_1;
    logic [7:0] gain_3;
    logic [7:0] gain_2;
    logic [7:0] gain_1;
    logic [7:0] contrast;
    logic [7:0] osd_contrast;
    logic [7:0] brightness;
    logic [7:0] control;
  } vpb_align_t;

  typedef struct packed {
    logic       signal_blank;
    logic       bright_blank;
    logic       pedestal_blank;
    logic       input_clamp;
    logic       output_clamp;
    logic       overlay_enable;
    logic [2:0] overlay_insert;
  } vpb_video_t;

  typedef struct packed {
    logic brightness_tracking_select;
    logic feedback_polarity_select;
    logic video_disable;
    logic overlay_disable;
  } vpb_ctrl_t;

endpackage

// ---- verif/vpb_i2c_master.sv ----
// bus master model standing in for the monitor controller
// assumes a pull-up on the data line; runs on its own timing, not the system clock
module vpb_i2c_master (
  // bus pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // quarter of the 400 ns bus period
  task automatic q;
    #100;
  endtask
  // data changes mid low phase so a late ack release cannot corrupt it
  task automatic bit_out(input logic b, output logic seen);
    q;
    sda_low = ~b;
    q;
    scl = 1'b1;
    q;
    seen = sda_line;
    q;
    scl = 1'b0;
  endtask
  // start, bytes, stop; gives up at the first nack
  task automatic xfer(input logic [7:0] a, input logic [7:0] sub, input logic [7:0] d[$], output int acks);
    logic       s;
    logic [7:0] by[$];
    by = {a, sub, d};
    acks = 0;
    #13;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
    foreach (by[k]) begin
      for (int i = 7; i >= 0; i--) bit_out(by[k][i], s);
      bit_out(1'b1, s);
      if (s) break;
      acks++;
    end
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
  endtask
endmodule

// ---- verif/video_preamp_bus_control_tb.sv ----
// self-checking bench for the video preamp bus control block
// assumes vpb_pkg and the bus master model are compiled first
module video_preamp_bus_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vpb_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, lfsr = 32'hF11CEA48, r;
  logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, vblank, scl, sda_low;
  logic [1:0] bresp, rresp, rs;
  logic cl_lo = 1'b0, cl_hi = 1'b0, fl_lo = 1'b0, fl_hi = 1'b0, fb = 1'b0, dip = 1'b0;
  logic [2:0] ov = 3'h0;
  logic [7:0] mreg[NUM_REGS], pval, cv[4] = '{8'h02, 8'h04, 8'h08, 8'h0D};
  logic flag = 1'b0, pend = 1'b0, vb, fl, oe;
  int n_errors = 0, n_tests = 0, pidx;
  vpb_align_t align;
  vpb_ctrl_t ctrl;
  vpb_video_t video;
  wire sda = ~(sda_low | (sda_oe & ~sda_o));
  always #25 aclk = ~aclk;
  vpb_bus_control DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .clamp_vblank_input_lo(cl_lo), .clamp_vblank_input_hi(cl_hi),
    .flyback_pulse_input_lo(fl_lo), .flyback_pulse_input_hi(fl_hi), .fast_blank_input(fb),
    .overlay_colour_inputs(ov), .supply_dip(dip), .align_o(align), .ctrl_o(ctrl), .video_o(video),
    .vblank_o(vblank));
  vpb_i2c_master PM (.scl(scl), .sda_low(sda_low), .sda_line(sda));
  function automatic logic [31:0] rnd;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [7:0] msk(input int i);
    return (i == 0 || i == 2) ? 8'h0F : (i == 10) ? 8'h07 : (i == 11) ? 8'h03 : 8'hFF;
  endfunction
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_regs;
    for (int i = 0; i < NUM_REGS; i++) cmp("reg", mreg[i], align[i*8+:8]);
    cmp("ctrl", {mreg[0][0], mreg[0][1], mreg[0][2], mreg[0][3]}, ctrl);
  endtask
  task automatic rst_model;
    foreach (mreg[i]) mreg[i] = 8'h00;
    mreg[0] = 8'h02;
    pend = 1'b0;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
    join
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    r = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // one bus frame; v below zero asks for random data
  task automatic iw(input logic [7:0] sub, input int n, input int v);
    logic [7:0] d[$];
    int a, e, i;
    i = sub[6:0];
    e = 1;
    for (int k = 0; k < n; k++) d.push_back((v < 0) ? 8'(rnd()) : 8'(v + k));
    if (i < NUM_REGS && !(sub[7] && pend)) begin
      e = 2;
      if (i == 0) flag = 1'b0;
      for (int k = 0; k < n && !flag && !(sub[7] && k > 0) && i + k < NUM_REGS; k++) begin
        e++;
        if (sub[7]) begin
          pend = 1'b1;
          pidx = i;
          pval = d[0] & msk(i);
        end else mreg[i+k] = d[k] & msk(i + k);
      end
    end
    PM.xfer({SLAVE_ADDR_INIT, 1'b0}, sub, d, a);
    repeat (4) @(posedge aclk);
    cmp("acks", e, a);
    chk_regs;
  endtask
  task automatic vpulse;
    cl_lo <= 1'b1;
    repeat (12) @(posedge aclk);
    cmp("vblank", 1, vblank);
    cmp("blank", 3'h7, video[8:6]);
    axi_rd(A_STATUS);
    cmp("status", {29'h0, 1'b1, 1'b0, flag}, r);
    cl_lo <= 1'b0;
    repeat (8) @(posedge aclk);
    if (pend) mreg[pidx] = pval;
    pend = 1'b0;
    cmp("vblank", 0, vblank);
    chk_regs;
  endtask
  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rst_model;
    repeat (4) @(posedge aclk);
    chk_regs;
    axi_rd(A_SLAVE);
    cmp("slave", {25'h0, SLAVE_ADDR_INIT}, r);
    axi_rd(8'h80);
    cmp("rresp", RESP_SLVERR, rs);
    axi_wr(8'h00, 32'h0);
    cmp("bresp", RESP_SLVERR, rs);
    axi_wr(A_SLAVE, {25'h0, SLAVE_ADDR_INIT});
    cmp("bresp", RESP_OKAY, rs);
    iw(8'h00, 13, -1);
    iw(8'h01, 2, -1);
    iw(8'h83, 1, -1);
    axi_rd(A_STATUS);
    cmp("status", {30'h0, pend, flag}, r);
    iw(8'h81, 1, -1);
    vpulse;
    iw(8'h82, 2, -1);
    vpulse;
    iw(8'h84, 1, -1);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rst_model;
    vpulse;
    iw(8'h00, 3, -1);
    dip <= 1'b1;
    repeat (6) @(posedge aclk);
    dip <= 1'b0;
    repeat (4) @(posedge aclk);
    flag = 1'b1;
    rst_model;
    chk_regs;
    axi_rd(A_STATUS);
    cmp("status", 32'h1, r);
    iw(8'h01, 1, -1);
    iw(8'h00, 0, -1);
    axi_rd(A_STATUS);
    cmp("status", 32'h0, r);
    iw(8'h00, 12, -1);
    axi_rd(8'h04);
    cmp("rdata", {24'h0, mreg[1]}, r);
    foreach (cv[c]) begin
      iw(8'h00, 1, cv[c]);
      repeat (16) begin
        r = rnd();
        cl_hi <= r[0];
        cl_lo <= r[0] | r[1];
        fl_hi <= r[2];
        fl_lo <= r[2] | r[3];
        fb <= r[4];
        ov <= r[7:5];
        repeat (14) @(posedge aclk);
        vb = r[1] & ~r[0];
        fl = r[2] | r[3];
        oe = r[4] & ~mreg[0][3];
        cmp("video", {vb | fl | oe | mreg[0][2], vb | fl, vb | fl, r[0], r[2], oe, oe ? r[7:5] : 3'h0},
            video);
      end
    end
    close_out;
  end
endmodule
